// ---- core/icf_defs.svh ----
// Constants of the interrupt control and flag block: register indexes, bit positions,
// masks, reset values and bus geometry.
// Assumes inclusion by bare name from any design file that needs these numbers.
`ifndef ICF_DEFS_SVH
`define ICF_DEFS_SVH

// Register indexes; byte address is four times the index.
`define ICF_IDX_W            11
`define ICF_IDX_CONTROL      11'h00b
`define ICF_IDX_FLAGS0       11'h70c
`define ICF_IDX_FLAGS1       11'h70d
`define ICF_IDX_FLAGS2       11'h70e
`define ICF_IDX_FLAGS3       11'h70f
`define ICF_ADDR_W           13

// Control register bit positions and reset value.
`define ICF_BIT_GIE          7
`define ICF_BIT_PERIPH_GROUP_ENABLE         6
`define ICF_BIT_EDGE         0
`define ICF_CONTROL_RESET    8'h01

// Flag register layouts.
`define ICF_BIT_TMR0         5
`define ICF_BIT_CHG          4
`define ICF_BIT_EXT          0
`define ICF_BIT_OSC          7
`define ICF_BIT_CSW          6
`define ICF_BIT_THR          1
`define ICF_BIT_CONV         0
`define ICF_BIT_ZC           6
`define ICF_BIT_CMP0         0
`define ICF_BIT_BCL0         1
`define ICF_BIT_SSP0         0
`define ICF_BIT_TX0          4
`define ICF_BIT_RX0          5
`define ICF_PORT_STRIDE      2

// Writable, hardware-set bits of each flag register.
`define ICF_RW_MASK0         8'h21
`define ICF_RW_MASK1         8'hc3
`define ICF_RW_MASK2         8'h43
`define ICF_RW_MASK3         8'h0f
`define ICF_FLAG_RESET       8'h00
`define ICF_VECTOR           16'h0004
`define ICF_VECTOR_RESET     16'h0000

`endif

// ---- core/icf_pkg.sv ----
// Types shared by the interrupt control and flag block.
// Assumes nothing of its surroundings; constants live in icf_defs.svh.
package icf_pkg;

   // Event and status inputs from the peripheral sources, sampled each clk_sys edge.
   typedef struct packed {
      logic       timer0_overflow;
      logic       change_detect_any;
      logic       ext_pin;
      logic       osc_fail;
      logic       clock_switch_ready;
      logic       converter_threshold;
      logic       converter_done;
      logic       zero_cross;
      logic [1:0] comparator;
      logic [1:0] serial_rx_not_empty;
      logic [1:0] serial_tx_space;
      logic [1:0] bus_collision;
      logic [1:0] sync_serial_done;
   } icf_event_type;

   // Contents of the four peripheral enable registers, kept outside this block.
   typedef struct packed {
      logic [7:0] enable3;
      logic [7:0] enable2;
      logic [7:0] enable1;
      logic [7:0] enable0;
   } icf_enable_type;

   typedef enum logic [0:0] {
      ICF_BUS_IDLE   = 1'b0,
      ICF_BUS_ANSWER = 1'b1
   } icf_bus_state_type;

   typedef enum logic [2:0] {
      ICF_SEL_NONE    = 3'b000,
      ICF_SEL_CONTROL = 3'b001,
      ICF_SEL_FLAGS0  = 3'b010,
      ICF_SEL_FLAGS1  = 3'b011,
      ICF_SEL_FLAGS2  = 3'b100,
      ICF_SEL_FLAGS3  = 3'b101
   } icf_sel_type;

endpackage

// ---- core/icf_top.sv ----
// Interrupt control register and peripheral flag registers 0 to 3, with an Avalon-MM slave.
// Assumes event inputs synchronous to clk_sys and enable registers held elsewhere.
//
// The Avalon-MM interface to the registers was chosen for this implementation.
`timescale 1ns/10ps
`include "icf_defs.svh"

module icf_top (
   input  wire logic                  clk_sys,
   input  wire logic                  sys_rst,
   input  wire logic [12:0]           avs_address,
   input  wire logic                  avs_read,
   input  wire logic                  avs_write,
   input  wire logic [31:0]           avs_writedata,
   input  wire logic [3:0]            avs_byteenable,
   output logic      [31:0]           avs_readdata,
   output logic                       avs_waitrequest,
   input  wire icf_pkg::icf_event_type events,
   input  wire icf_pkg::icf_enable_type enables,
   input  wire logic                  irq_return,
   output logic                       irq_take,
   output logic      [15:0]           irq_vector
);

   // ----------------------------------------------------------------------------
   // Address decode
   // ----------------------------------------------------------------------------

   // Maps a byte address to a register; misaligned or unlisted addresses select nothing.
   function automatic icf_pkg::icf_sel_type decode_sel(input logic [12:0] addr);
      logic [`ICF_IDX_W-1:0] idx;
      idx = addr[12:2];
      decode_sel = icf_pkg::ICF_SEL_NONE;
      if (addr[1:0] == 2'h0) begin
         case (idx)
            `ICF_IDX_CONTROL: decode_sel = icf_pkg::ICF_SEL_CONTROL;
            `ICF_IDX_FLAGS0:  decode_sel = icf_pkg::ICF_SEL_FLAGS0;
            `ICF_IDX_FLAGS1:  decode_sel = icf_pkg::ICF_SEL_FLAGS1;
            `ICF_IDX_FLAGS2:  decode_sel = icf_pkg::ICF_SEL_FLAGS2;
            `ICF_IDX_FLAGS3:  decode_sel = icf_pkg::ICF_SEL_FLAGS3;
            default:          decode_sel = icf_pkg::ICF_SEL_NONE;
         endcase
      end
   endfunction

   // Sticky flag update: a written zero clears a writable bit, a hardware set wins.
   function automatic logic [7:0] flag_next(input logic [7:0] cur, input logic [7:0] set,
                                            input logic wr, input logic [7:0] wdata,
                                            input logic [7:0] mask);
      logic [7:0] clr;
      clr = wr ? (~wdata & mask) : 8'h00;
      flag_next = ((cur & ~clr) | set) & mask;
   endfunction

   // ----------------------------------------------------------------------------
   // State
   // ----------------------------------------------------------------------------

   icf_pkg::icf_bus_state_type bus_state_q, bus_state_d;
   logic [31:0]                readdata_q, readdata_d;
   logic                       wait_q, wait_d;
   logic [7:0]                 control_q, control_d;
   logic [7:0]                 flags0_q, flags0_d;
   logic [7:0]                 flags1_q, flags1_d;
   logic [7:0]                 flags2_q, flags2_d;
   logic [7:0]                 flags3_q, flags3_d;
   logic                       pin_prev_q, pin_prev_d;
   logic                       pin_valid_q, pin_valid_d;
   logic                       take_q, take_d;
   logic [15:0]                vector_q, vector_d;

   logic [7:0]                 set0, set1, set2, set3;
   logic [7:0]                 live3;
   logic [7:0]                 view0, view3;
   logic                       ext_hit;
   logic                       req;
   logic                       commit_wr;
   icf_pkg::icf_sel_type       sel;
   logic [7:0]                 wbyte;
   logic                       pend_core, pend_periph;

   // ----------------------------------------------------------------------------
   // Event sources
   // ----------------------------------------------------------------------------

   // The pin history is ignored for one cycle after reset so a pin that is already
   // high or low at release does not count as an edge.
   assign ext_hit = pin_valid_q & (control_q[`ICF_BIT_EDGE] ?
                    (events.ext_pin & ~pin_prev_q) : (~events.ext_pin & pin_prev_q));

   // Hardware set vectors, independent of every enable bit.
   always_comb begin
      set0 = 8'h00;
      set1 = 8'h00;
      set2 = 8'h00;
      set0[`ICF_BIT_TMR0] = events.timer0_overflow;
      set0[`ICF_BIT_EXT]  = ext_hit;
      set1[`ICF_BIT_OSC]  = events.osc_fail;
      set1[`ICF_BIT_CSW]  = events.clock_switch_ready;
      set1[`ICF_BIT_THR]  = events.converter_threshold;
      set1[`ICF_BIT_CONV] = events.converter_done;
      set2[`ICF_BIT_ZC]   = events.zero_cross;
      set2[`ICF_BIT_CMP0 + 1] = events.comparator[1];
      set2[`ICF_BIT_CMP0] = events.comparator[0];
   end

   // Each serial port contributes the same four bits at a stride of two.
   generate
      for (genvar p = 0; p < 2; p++) begin : g_port
         assign set3[`ICF_BIT_SSP0 + `ICF_PORT_STRIDE*p] = events.sync_serial_done[p];
         assign set3[`ICF_BIT_BCL0 + `ICF_PORT_STRIDE*p] = events.bus_collision[p];
         assign set3[`ICF_BIT_TX0 + `ICF_PORT_STRIDE*p]  = 1'b0;
         assign set3[`ICF_BIT_RX0 + `ICF_PORT_STRIDE*p]  = 1'b0;
         assign live3[`ICF_BIT_SSP0 + `ICF_PORT_STRIDE*p] = 1'b0;
         assign live3[`ICF_BIT_BCL0 + `ICF_PORT_STRIDE*p] = 1'b0;
         assign live3[`ICF_BIT_TX0 + `ICF_PORT_STRIDE*p]  = events.serial_tx_space[p];
         assign live3[`ICF_BIT_RX0 + `ICF_PORT_STRIDE*p]  = events.serial_rx_not_empty[p];
      end
   endgenerate

   // Read views merge stored flags with live, read-only status bits.
   always_comb begin
      view0 = flags0_q;
      view0[`ICF_BIT_CHG] = events.change_detect_any;
      view3 = flags3_q | live3;
   end

   // ----------------------------------------------------------------------------
   // Avalon-MM slave
   // ----------------------------------------------------------------------------

   // A request is seen in idle, answered with waitrequest low one cycle later; the
   // write lands at that completing edge, where the master also takes read data.
   assign req       = avs_read | avs_write;
   assign sel       = decode_sel(avs_address);
   assign commit_wr = (bus_state_q == icf_pkg::ICF_BUS_ANSWER) & avs_write & avs_byteenable[0];
   assign wbyte     = avs_writedata[7:0];

   always_comb begin
      bus_state_d = bus_state_q;
      wait_d      = 1'b1;
      readdata_d  = readdata_q;
      case (bus_state_q)
         icf_pkg::ICF_BUS_IDLE: begin
            if (req) begin
               bus_state_d = icf_pkg::ICF_BUS_ANSWER;
               wait_d      = 1'b0;
               readdata_d  = 32'h0000_0000;
               case (sel)
                  icf_pkg::ICF_SEL_CONTROL: readdata_d[7:0] = control_q;
                  icf_pkg::ICF_SEL_FLAGS0:  readdata_d[7:0] = view0;
                  icf_pkg::ICF_SEL_FLAGS1:  readdata_d[7:0] = flags1_q;
                  icf_pkg::ICF_SEL_FLAGS2:  readdata_d[7:0] = flags2_q;
                  icf_pkg::ICF_SEL_FLAGS3:  readdata_d[7:0] = view3;
                  default:                  readdata_d[7:0] = 8'h00;
               endcase
            end
         end
         icf_pkg::ICF_BUS_ANSWER: begin
            bus_state_d = icf_pkg::ICF_BUS_IDLE;
         end
         default: begin
            bus_state_d = icf_pkg::ICF_BUS_IDLE;
         end
      endcase
   end

   // ----------------------------------------------------------------------------
   // Registers and interrupt take
   // ----------------------------------------------------------------------------

   // Peripheral-register enables pass only under the group enable; register 0 does not
   // need it. The take pulse clears the global enable and is itself the vector fetch.
   always_comb begin
      pend_core   = |(view0 & enables.enable0);
      pend_periph = control_q[`ICF_BIT_PERIPH_GROUP_ENABLE] & (|(flags1_q & enables.enable1) |
                    |(flags2_q & enables.enable2) | |(view3 & enables.enable3));
      take_d      = control_q[`ICF_BIT_GIE] & ~take_q & (pend_core | pend_periph);
      vector_d    = take_d ? `ICF_VECTOR : vector_q;

      control_d = control_q;
      if (commit_wr && sel == icf_pkg::ICF_SEL_CONTROL) begin
         control_d[`ICF_BIT_GIE]  = wbyte[`ICF_BIT_GIE];
         control_d[`ICF_BIT_PERIPH_GROUP_ENABLE] = wbyte[`ICF_BIT_PERIPH_GROUP_ENABLE];
         control_d[`ICF_BIT_EDGE] = wbyte[`ICF_BIT_EDGE];
      end
      if (irq_return) begin
         control_d[`ICF_BIT_GIE] = 1'b1;
      end
      if (take_d) begin
         control_d[`ICF_BIT_GIE] = 1'b0;
      end

      flags0_d = flag_next(flags0_q, set0, commit_wr && sel == icf_pkg::ICF_SEL_FLAGS0,
                           wbyte, `ICF_RW_MASK0);
      flags1_d = flag_next(flags1_q, set1, commit_wr && sel == icf_pkg::ICF_SEL_FLAGS1,
                           wbyte, `ICF_RW_MASK1);
      flags2_d = flag_next(flags2_q, set2, commit_wr && sel == icf_pkg::ICF_SEL_FLAGS2,
                           wbyte, `ICF_RW_MASK2);
      flags3_d = flag_next(flags3_q, set3, commit_wr && sel == icf_pkg::ICF_SEL_FLAGS3,
                           wbyte, `ICF_RW_MASK3);

      pin_prev_d  = events.ext_pin;
      pin_valid_d = 1'b1;
   end

   always_ff @(posedge clk_sys) begin
      if (sys_rst) begin
         bus_state_q <= icf_pkg::ICF_BUS_IDLE;
         wait_q      <= 1'b1;
         readdata_q  <= 32'h0000_0000;
         control_q   <= `ICF_CONTROL_RESET;
         flags0_q    <= `ICF_FLAG_RESET;
         flags1_q    <= `ICF_FLAG_RESET;
         flags2_q    <= `ICF_FLAG_RESET;
         flags3_q    <= `ICF_FLAG_RESET;
         pin_prev_q  <= 1'b0;
         pin_valid_q <= 1'b0;
         take_q      <= 1'b0;
         vector_q    <= `ICF_VECTOR_RESET;
      end else begin
         bus_state_q <= bus_state_d;
         wait_q      <= wait_d;
         readdata_q  <= readdata_d;
         control_q   <= control_d;
         flags0_q    <= flags0_d;
         flags1_q    <= flags1_d;
         flags2_q    <= flags2_d;
         flags3_q    <= flags3_d;
         pin_prev_q  <= pin_prev_d;
         pin_valid_q <= pin_valid_d;
         take_q      <= take_d;
         vector_q    <= vector_d;
      end
   end

   assign avs_readdata    = readdata_q;
   assign avs_waitrequest = wait_q;
   assign irq_take        = take_q;
   assign irq_vector      = vector_q;

   // ----------------------------------------------------------------------------
   // Checks
   // ----------------------------------------------------------------------------

   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (sys_rst);

   sequence s_request_seen;
      bus_state_q == icf_pkg::ICF_BUS_IDLE && req;
   endsequence

   sequence s_answer;
      !avs_waitrequest ##1 avs_waitrequest;
   endsequence

   bus_answer_timing_a: assert property (s_request_seen |=> s_answer)
      else $error("Request not answered in one cycle.");

   take_needs_gie_a: assert property (irq_take |-> $past(control_q[`ICF_BIT_GIE]))
      else $error("Interrupt taken without global enable.");

   periph_gate_a: assert property (
      !control_q[`ICF_BIT_PERIPH_GROUP_ENABLE] && !pend_core |=> !irq_take)
      else $error("Peripheral interrupt passed a closed group enable.");

   edge_select_a: assert property (
      pin_valid_q && control_q[`ICF_BIT_EDGE] && events.ext_pin && !pin_prev_q
      |=> flags0_q[`ICF_BIT_EXT])
      else $error("Rising edge did not set the external flag.");

   timer_flag_set_a: assert property (events.timer0_overflow |=> flags0_q[`ICF_BIT_TMR0])
      else $error("Timer overflow flag not set.");

   change_summary_a: assert property (
      s_request_seen and (sel == icf_pkg::ICF_SEL_FLAGS0)
      |=> avs_readdata[`ICF_BIT_CHG] == $past(events.change_detect_any))
      else $error("Change summary bit does not follow its source.");

   set_beats_clear_a: assert property (
      commit_wr && sel == icf_pkg::ICF_SEL_FLAGS1 && events.osc_fail
      |=> flags1_q[`ICF_BIT_OSC])
      else $error("Hardware set lost to a software clear.");

   flag_holds_a: assert property (
      flags1_q[`ICF_BIT_OSC] && !commit_wr |=> flags1_q[`ICF_BIT_OSC])
      else $error("Oscillator flag dropped without a write.");

   take_clears_gie_a: assert property (
      irq_take |-> !control_q[`ICF_BIT_GIE] && irq_vector == `ICF_VECTOR ##1 !irq_take)
      else $error("Take did not clear global enable or load vector.");

   rx_live_a: assert property (
      s_request_seen and (sel == icf_pkg::ICF_SEL_FLAGS3)
      |=> avs_readdata[`ICF_BIT_RX0] == $past(events.serial_rx_not_empty[0]))
      else $error("Receive flag does not follow the buffer state.");

   tx_live_a: assert property (
      s_request_seen and (sel == icf_pkg::ICF_SEL_FLAGS3)
      |=> avs_readdata[`ICF_BIT_TX0] == $past(events.serial_tx_space[0]))
      else $error("Transmit flag does not follow the buffer state.");

   falling_edge_a: assert property (
      pin_valid_q && !control_q[`ICF_BIT_EDGE] && !events.ext_pin && pin_prev_q
      |=> flags0_q[`ICF_BIT_EXT])
      else $error("Falling edge did not set the external flag.");

   clear_lands_a: assert property (
      commit_wr && sel == icf_pkg::ICF_SEL_FLAGS1 && !wbyte[`ICF_BIT_OSC] && !events.osc_fail
      |=> !flags1_q[`ICF_BIT_OSC])
      else $error("Written zero did not clear the oscillator flag.");

   threshold_flag_a: assert property (events.converter_threshold |=> flags1_q[`ICF_BIT_THR])
      else $error("Converter threshold flag not set.");

   comparator_flag_a: assert property (events.comparator[1] |=> flags2_q[`ICF_BIT_CMP0 + 1])
      else $error("Second comparator flag not set.");

   collision_flag_a: assert property (
      events.bus_collision[1] |=> flags3_q[`ICF_BIT_BCL0 + `ICF_PORT_STRIDE])
      else $error("Second port bus collision flag not set.");

   sync_flag_a: assert property (
      events.sync_serial_done[0] |=> flags3_q[`ICF_BIT_SSP0])
      else $error("Serial completion flag not set.");

endmodule

// ---- sim/icf_source_model.sv ----
// Behavioural model of the peripheral event sources that face icf_top.
// Assumes its tasks are entered just after a rising edge of clk_sys.
`timescale 1ns/10ps
module icf_source_model (
   input  wire logic              clk_sys,
   output icf_pkg::icf_event_type events
);
   icf_pkg::icf_event_type pulse_q;
   icf_pkg::icf_event_type level_q;

   // Sticky sources fire as one-cycle pulses; live levels persist until changed.
   assign events = pulse_q | level_q;

   // Everything is quiet at time zero, so no spurious event is seen in reset.
   initial begin
      pulse_q = '0;
      level_q = '0;
   end

   // One-cycle event; the trailing edge keeps two calls from meeting in one time step.
   task automatic pulse(input icf_pkg::icf_event_type ev);
      pulse_q <= ev;
      @(posedge clk_sys);
      pulse_q <= '0;
      @(posedge clk_sys);
   endtask

   // Pin level, change summary and serial buffer states, held until the next call.
   task automatic set_level(input icf_pkg::icf_event_type ev);
      level_q <= ev;
      @(posedge clk_sys);
   endtask
endmodule

// ---- sim/interrupt_control_flags_test.sv ----
// Self-checking testbench of icf_top: register access, flag setting and clearing, interrupt take.
// Assumes icf_pkg is compiled first and icf_source_model drives the event inputs.
`timescale 1ns/10ps
module interrupt_control_flags_test;
   localparam logic [12:0] A_CTL = 13'h002c;
   localparam logic [12:0] A_F0  = 13'h1c30;
   localparam logic [12:0] A_F1  = 13'h1c34;
   localparam logic [12:0] A_F2  = 13'h1c38;
   localparam logic [12:0] A_F3  = 13'h1c3c;
   localparam int          NS    = 12;

   logic                    clk_sys;
   logic                    sys_rst;
   logic [12:0]             avs_address;
   logic                    avs_read;
   logic                    avs_write;
   logic [31:0]             avs_writedata;
   logic [3:0]              avs_byteenable;
   logic [31:0]             avs_readdata;
   logic                    avs_waitrequest;
   icf_pkg::icf_event_type  events;
   icf_pkg::icf_enable_type enables;
   logic                    irq_return;
   logic                    irq_take;
   logic [15:0]             irq_vector;
   icf_pkg::icf_event_type  ev;
   int                      fail_count = 0;
   int                      n_compared = 0;
   int                      takes      = 0;
   int                      spos [NS]  = '{17, 14, 13, 12, 11, 10, 8, 9, 2, 3, 0, 1};
   logic [12:0]             sreg [NS]  = '{A_F0, A_F1, A_F1, A_F1, A_F1, A_F2, A_F2, A_F2, A_F3, A_F3, A_F3, A_F3};
   logic [7:0]              sbit [NS]  = '{8'h20, 8'h80, 8'h40, 8'h02, 8'h01, 8'h40, 8'h01, 8'h02,
                                           8'h02, 8'h08, 8'h01, 8'h04};

   icf_top DUT (.clk_sys(clk_sys), .sys_rst(sys_rst), .avs_address(avs_address), .avs_read(avs_read),
      .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
      .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .events(events), .enables(enables),
      .irq_return(irq_return), .irq_take(irq_take), .irq_vector(irq_vector));
   icf_source_model src (.clk_sys(clk_sys), .events(events));

   // ----------------------------------------------------------------
   // Clock, take monitor and shared tasks
   // ----------------------------------------------------------------
   // Free-running 40 MHz clock.
   always #12.5 clk_sys = ~clk_sys;

   // Takes are counted mid-cycle, where the pulse is settled.
   always @(negedge clk_sys) begin
      if (irq_take === 1'b1) takes++;
   end

   task automatic check(input logic [15:0] got, input logic [15:0] exp);
      n_compared++;
      if (got !== exp) begin
         fail_count++;
         $display("MISMATCH at %0t: got %h expected %h", $time, got, exp);
      end
   endtask

   // One Avalon transfer; waitrequest and read data are taken at the rising edge that ends it.
   // The request stands until then; a slave that never answers is left to the watchdog.
   task automatic bus(input logic wr, input logic [12:0] addr, input logic [7:0] wdata, output logic [7:0] rdata);
      avs_address <= addr;
      avs_writedata <= {24'h000000, wdata};
      avs_write <= wr;
      avs_read <= ~wr;
      do begin
         @(posedge clk_sys);
      end while (avs_waitrequest !== 1'b0);
      rdata = avs_readdata[7:0];
      avs_read <= 1'b0;
      avs_write <= 1'b0;
      @(posedge clk_sys);
   endtask

   task automatic wr(input logic [12:0] addr, input logic [7:0] data);
      logic [7:0] unused;
      bus(1'b1, addr, data, unused);
   endtask

   task automatic rd(input logic [12:0] addr, input logic [7:0] exp);
      logic [7:0] got;
      bus(1'b0, addr, 8'h00, got);
      check({8'h00, got}, {8'h00, exp});
   endtask

   task automatic finish_test();
      $display("Compared %0d, mismatches %0d", n_compared, fail_count);
      if (fail_count == 0 && n_compared > 0) begin
         $display("DONE - PASS");
      end else begin
         $display("DONE - FAIL");
      end
      $finish;
   endtask

   // A hang is cut short well beyond the few hundred cycles the tests need.
   initial begin
      repeat (20000) @(posedge clk_sys);
      fail_count++;
      $display("MISMATCH at %0t: watchdog expired", $time);
      finish_test();
   end

   // ----------------------------------------------------------------
   // Test sequence
   // ----------------------------------------------------------------
   initial begin
      clk_sys = 1'b0;
      sys_rst = 1'b1;
      avs_address = '0;
      avs_read = 1'b0;
      avs_write = 1'b0;
      avs_writedata = '0;
      avs_byteenable = 4'h1;
      enables = '0;
      irq_return = 1'b0;
      repeat (20) @(posedge clk_sys);
      sys_rst <= 1'b0;
      @(posedge clk_sys);
      // Reset values, plus an unmapped address that must read zero.
      rd(A_CTL, 8'h01);
      foreach (sreg[i]) rd(sreg[i], 8'h00);
      rd(13'h0000, 8'h00);
      // A write without its low byte lane enabled must be dropped.
      avs_byteenable <= 4'he;
      wr(A_CTL, 8'h80);
      avs_byteenable <= 4'h1;
      rd(A_CTL, 8'h01);
      check(irq_vector, 16'h0000);
      $display("Test reset done");
      // Each sticky flag but the external-pin one: ones written do nothing, the event sets it, a zero clears it.
      for (int i = 0; i < NS; i++) begin
         ev = '0;
         ev[spos[i]] = 1'b1;
         wr(sreg[i], 8'hff);
         rd(sreg[i], 8'h00);
         src.pulse(ev);
         rd(sreg[i], sbit[i]);
         wr(sreg[i], 8'h00);
         rd(sreg[i], 8'h00);
      end
      $display("Test sticky flags done");
      // A source held high across the clearing write keeps its flag.
      ev = '0;
      ev.osc_fail = 1'b1;
      src.set_level(ev);
      wr(A_F1, 8'h00);
      rd(A_F1, 8'h80);
      src.set_level('0);
      wr(A_F1, 8'h00);
      rd(A_F1, 8'h00);
      $display("Test set wins done");
      // Live bits follow their sources and ignore writes.
      ev = '0;
      ev.change_detect_any = 1'b1;
      ev.serial_rx_not_empty = 2'b11;
      ev.serial_tx_space = 2'b01;
      src.set_level(ev);
      wr(A_F0, 8'h00);
      rd(A_F0, 8'h10);
      wr(A_F3, 8'h00);
      // Port 2 reads full, so the bench gives it no transmit data.
      rd(A_F3, 8'hb0);
      src.set_level('0);
      rd(A_F0, 8'h00);
      rd(A_F3, 8'h00);
      $display("Test live bits done");
      // External pin: rising edge by default, falling edge once selected, rising then ignored.
      ev = '0;
      ev.ext_pin = 1'b1;
      src.set_level(ev);
      rd(A_F0, 8'h01);
      wr(A_F0, 8'h00);
      wr(A_CTL, 8'h00);
      src.set_level('0);
      rd(A_F0, 8'h01);
      wr(A_F0, 8'h00);
      src.set_level(ev);
      rd(A_F0, 8'h00);
      wr(A_CTL, 8'h01);
      src.set_level('0);
      rd(A_F0, 8'h00);
      $display("Test external edge done");
      // Take: flagged with the global enable off, blocked without the group enable, taken with it.
      enables.enable1 <= 8'h80;
      ev = '0;
      ev.osc_fail = 1'b1;
      src.pulse(ev);
      rd(A_F1, 8'h80);
      wr(A_CTL, 8'h81);
      rd(A_CTL, 8'h81);
      check(16'(takes), 16'h0000);
      wr(A_CTL, 8'hc1);
      rd(A_CTL, 8'h41);
      check(16'(takes), 16'h0001);
      check(irq_vector, 16'h0004);
      wr(A_F1, 8'h00);
      irq_return <= 1'b1;
      @(posedge clk_sys);
      irq_return <= 1'b0;
      @(posedge clk_sys);
      rd(A_CTL, 8'hc1);
      check(16'(takes), 16'h0001);
      // Enable register 0 is not gated by the group enable.
      wr(A_CTL, 8'h81);
      enables.enable0 <= 8'h20;
      ev = '0;
      ev.timer0_overflow = 1'b1;
      src.pulse(ev);
      rd(A_CTL, 8'h01);
      check(16'(takes), 16'h0002);
      wr(A_F0, 8'h00);
      $display("Test interrupt take done");
      finish_test();
   end
endmodule
